// ===== hdl/acdpc_top.sv
// module: clock divider, duty stabilizer and power control
`timescale 1ns/1ps
module acdpc_top import acdpc_pkg::*; #(
    parameter logic [15:0] WAKE_MAX_CYC = 16'h0400
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic sample_clk_in,
    input wire logic align_in,
    input wire logic powerdown_pin,
    input wire logic ref_sense_high,
    input wire logic [3:0] div_ratio,
    input wire logic duty_cycle_stabilizer_en,
    input wire logic spi_powerdown,
    input wire logic spi_standby,
    input wire logic lvds_reduced,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [12:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic sample_strobe,
    output logic int_clk,
    output logic dcs_locked,
    output logic ref_en,
    output logic int_ref_en,
    output logic ext_ref_sel,
    output logic refbuf_en,
    output logic bias_en,
    output logic core_clk_en,
    output logic drv_oe,
    output logic core_ready,
    output logic [1:0] drive_current_code
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    acdpc_pin_if #(.W(PIN_COUNT)) pins ();

    // the sample clock is oversampled; inputs near 50 MHz and up alias
    assign pins.raw = {ref_sense_high, powerdown_pin, align_in, sample_clk_in};

    acdpc_pin_sync #(.W(PIN_COUNT)) u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pins(pins)
    );

    wire in_rise = pins.rise[PIN_SAMPLE_CLK];
    wire in_fall = pins.fall[PIN_SAMPLE_CLK];
    wire align_rise = pins.rise[PIN_ALIGN];
    wire pd_pin_lvl = pins.level[PIN_POWERDOWN_PIN];
    wire sense_lvl = pins.level[PIN_SENSE];

    ////////////////////////////////////////////////////////////////////
    // alignment control register
    logic [1:0] ctrl_ff;
    logic armed_ff;
    logic [7:0] rdata_ff;

    wire addr_hit = (reg_addr == ALIGN_CTRL_ADDR);
    wire wr_hit = reg_wr_en && addr_hit;
    wire rd_hit = reg_rd_en && addr_hit;
    wire align_en = ctrl_ff[ALIGN_EN_BIT];
    wire align_once = ctrl_ff[ALIGN_ONCE_BIT];
    // once mode takes only the first pulse after a write
    wire align_acc = align_rise && align_en && (!align_once || armed_ff);
    // a write in the same cycle as a taken pulse keeps the arm set
    wire nxt_armed = wr_hit ? 1'b1 : ((align_acc && align_once) ? 1'b0 : armed_ff);
    wire [7:0] rd_word = {5'h00, armed_ff, ctrl_ff};

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_ff <= ALIGN_CTRL_RST;
            armed_ff <= 1'b0;
            rdata_ff <= RDATA_IDLE;
        end else begin
            if (wr_hit) begin
                ctrl_ff <= reg_wdata[1:0];
            end
            armed_ff <= nxt_armed;
            rdata_ff <= rd_hit ? rd_word : RDATA_IDLE;
        end
    end

    assign reg_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////
    // power state
    logic sleep_d_ff;
    logic ref_en_ff;
    logic [15:0] down_time_ff;
    logic [15:0] wake_cnt_ff;

    wire pd_req = spi_powerdown || pd_pin_lvl;
    wire sleep = pd_req || spi_standby;
    wire wake_go = sleep_d_ff && !sleep;
    // reference kept alive in standby, so charge time is a quarter
    wire [15:0] wake_load = ref_en_ff ? {2'h0, down_time_ff[15:2]} : down_time_ff;
    wire [15:0] nxt_down = sleep ?
        ((down_time_ff < WAKE_MAX_CYC) ? down_time_ff + 16'h0001 : down_time_ff) :
        (wake_go ? 16'h0000 : down_time_ff);
    wire [15:0] nxt_wake = wake_go ? wake_load :
        ((wake_cnt_ff != 16'h0000) ? wake_cnt_ff - 16'h0001 : 16'h0000);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sleep_d_ff <= 1'b0;
            ref_en_ff <= 1'b1;
            down_time_ff <= 16'h0000;
            wake_cnt_ff <= 16'h0000;
        end else begin
            sleep_d_ff <= sleep;
            ref_en_ff <= !pd_req;
            down_time_ff <= nxt_down;
            wake_cnt_ff <= nxt_wake;
        end
    end

    // everything but the reference follows the sleep state
    assign ref_en = ref_en_ff;
    assign refbuf_en = !sleep_d_ff;
    assign bias_en = !sleep_d_ff;
    assign core_clk_en = !sleep_d_ff;
    assign drv_oe = !sleep_d_ff;
    assign core_ready = !sleep_d_ff && (wake_cnt_ff == 16'h0000);

    ////////////////////////////////////////////////////////////////////
    // reference select and output driver mode
    logic ext_ref_ff;
    logic [1:0] drv_code_ff;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ext_ref_ff <= 1'b0;
            drv_code_ff <= DRV_STD_3P5MA;
        end else begin
            ext_ref_ff <= sense_lvl;
            drv_code_ff <= lvds_reduced ? DRV_REDUCED_2MA : DRV_STD_3P5MA;
        end
    end

    assign ext_ref_sel = ext_ref_ff;
    assign int_ref_en = ref_en_ff && !ext_ref_ff;
    assign drive_current_code = drv_code_ff;

    ////////////////////////////////////////////////////////////////////
    // integer divider
    logic [2:0] cnt_ff;
    logic strobe_ff;

    wire [3:0] ratio = acdpc_clamp_ratio(div_ratio);
    wire [2:0] ratio_m1 = 3'(ratio - 4'h1);
    wire cnt_wrap = (cnt_ff >= ratio_m1);
    // a sample is taken on the input edge that starts a count
    wire samp_go = in_rise && (cnt_ff == 3'h0) && !sleep;
    // alignment wins over counting and restarts at the first state
    wire [2:0] nxt_cnt = align_acc ? 3'h0 :
        (in_rise ? (cnt_wrap ? 3'h0 : cnt_ff + 3'h1) : cnt_ff);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 3'h0;
            strobe_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            strobe_ff <= samp_go;
        end
    end

    assign sample_strobe = strobe_ff;

    ////////////////////////////////////////////////////////////////////
    // input period watch and stabilizer lock
    logic [7:0] per_cnt_ff;
    logic [7:0] in_period_ff;
    logic [9:0] relock_ff;
    logic locked_ff;

    wire [7:0] per_inc = (per_cnt_ff == 8'hFF) ? 8'hFF : per_cnt_ff + 8'h01;
    wire [7:0] per_diff = (per_inc > in_period_ff) ?
        per_inc - in_period_ff : in_period_ff - per_inc;
    // a rate change of more than one cycle, or a dead input, restarts the relock wait
    wire period_jump = (in_rise && (per_diff > 8'h01)) || (per_cnt_ff == 8'hFF);
    wire rate_ok = (in_period_ff != 8'h00) && (in_period_ff <= DCS_MAX_PERIOD);
    wire [9:0] nxt_relock = (period_jump || !duty_cycle_stabilizer_en) ? RELOCK_LOAD :
        ((relock_ff != 10'h000) ? relock_ff - 10'h001 : 10'h000);
    wire nxt_locked = duty_cycle_stabilizer_en && rate_ok && (relock_ff == 10'h000);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            per_cnt_ff <= 8'h00;
            in_period_ff <= 8'h00;
            relock_ff <= RELOCK_LOAD;
            locked_ff <= 1'b0;
        end else begin
            per_cnt_ff <= in_rise ? 8'h00 : per_inc;
            if (in_rise) begin
                in_period_ff <= per_inc;
            end
            relock_ff <= nxt_relock;
            locked_ff <= nxt_locked && !period_jump;
        end
    end

    assign dcs_locked = locked_ff;

    ////////////////////////////////////////////////////////////////////
    // internal sample clock with optional duty regeneration
    logic [7:0] samp_cnt_ff;
    logic [7:0] samp_period_ff;
    logic int_clk_ff;

    wire [7:0] samp_inc = (samp_cnt_ff == 8'hFF) ? 8'hFF : samp_cnt_ff + 8'h01;
    wire [7:0] half_period = {1'b0, samp_period_ff[7:1]};
    // unlocked loop falls back to the input's own falling edge
    wire dcs_use = duty_cycle_stabilizer_en && locked_ff;
    wire fall_now = dcs_use ? (samp_inc >= half_period) : in_fall;
    wire nxt_int_clk = sleep ? 1'b0 : (samp_go ? 1'b1 : (fall_now ? 1'b0 : int_clk_ff));

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            samp_cnt_ff <= 8'h00;
            samp_period_ff <= 8'h00;
            int_clk_ff <= 1'b0;
        end else begin
            samp_cnt_ff <= samp_go ? 8'h00 : samp_inc;
            if (samp_go) begin
                samp_period_ff <= samp_inc;
            end
            int_clk_ff <= nxt_int_clk;
        end
    end

    assign int_clk = int_clk_ff;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_div_wrap: assert property (
        (in_rise && !align_acc && cnt_wrap) |=> (cnt_ff == 3'h0))
        else $error("divider did not wrap at the ratio");

    a_div_hold: assert property (
        (!in_rise && !align_acc) |=> $stable(cnt_ff))
        else $error("divider moved without an input edge");

    a_once_disarm: assert property (
        (align_acc && align_once && !wr_hit) |=> !armed_ff ##1 (!align_acc [*1]))
        else $error("once mode accepted a second alignment pulse");

    a_align_restart: assert property (
        align_acc |=> (cnt_ff == 3'h0))
        else $error("alignment pulse did not restart the divider");

    a_dcs_half: assert property (
        (int_clk_ff && dcs_use && !samp_go && !sleep && samp_inc >= half_period)
        |=> !int_clk_ff)
        else $error("stabilized clock missed its half period fall");

    a_dcs_slow: assert property (
        (in_period_ff > DCS_MAX_PERIOD) |-> !locked_ff)
        else $error("stabilizer claims lock below the minimum rate");

    a_relock_wait: assert property (
        (period_jump && duty_cycle_stabilizer_en) |=> !locked_ff [*8])
        else $error("stabilizer relocked too soon after a rate change");

    a_pd_enter: assert property (
        pd_pin_lvl |=> (!drv_oe && !core_clk_en && !int_clk_ff))
        else $error("power-down pin did not stop the device");

    a_pd_hiz: assert property (
        (spi_powerdown || spi_standby) |=> !drv_oe)
        else $error("drivers left enabled while asleep");

    a_pd_release: assert property (
        ($fell(pd_pin_lvl) && !spi_powerdown && !spi_standby) |=> drv_oe)
        else $error("pin low did not return to normal operation");

    a_wake_delay: assert property (
        (wake_go && wake_load > 16'h0001) |=> !core_ready [*2])
        else $error("core reported ready without wake-up delay");

    a_standby_ref: assert property (
        (spi_standby && !pd_req) |=> (ref_en && !bias_en))
        else $error("standby did not keep the reference alone powered");

    a_ref_select: assert property (
        sense_lvl |=> (ext_ref_sel && !int_ref_en))
        else $error("high sense level did not select external reference");

    a_drive_mode: assert property (
        !lvds_reduced |=> (drive_current_code == DRV_STD_3P5MA))
        else $error("driver not in standard current mode");

    a_sample_edge: assert property (
        samp_go |=> (sample_strobe && int_clk_ff))
        else $error("sample strobe not aligned with clock rise");
endmodule

// ===== hdl/acdpc_pkg.sv
// package: constants for the clock divider and power control block
package acdpc_pkg;
    // divider alignment control register
    localparam logic [12:0] ALIGN_CTRL_ADDR = 13'h109;
    localparam int ALIGN_EN_BIT = 0;
    localparam int ALIGN_ONCE_BIT = 1;
    localparam int ALIGN_ARMED_BIT = 2;
    localparam logic [1:0] ALIGN_CTRL_RST = 2'h0;
    localparam logic [7:0] RDATA_IDLE = 8'h00;
    // divider range
    localparam logic [3:0] DIV_MIN = 4'h1;
    localparam logic [3:0] DIV_MAX = 4'h8;
    // stabilizer timing at the system clock rate
    localparam int CLK_MHZ = 200;
    localparam int DCS_MIN_MHZ = 20;
    localparam logic [7:0] DCS_MAX_PERIOD = 8'(CLK_MHZ / DCS_MIN_MHZ);
    localparam int RELOCK_MAX_NS = 5000;
    localparam int RELOCK_CYC = RELOCK_MAX_NS * CLK_MHZ / 1000;
    localparam logic [9:0] RELOCK_LOAD = 10'(RELOCK_CYC);
    // output driver current codes
    localparam logic [1:0] DRV_STD_3P5MA = 2'h0;
    localparam logic [1:0] DRV_REDUCED_2MA = 2'h1;
    // pin positions in the synchroniser bundle
    localparam int PIN_SAMPLE_CLK = 0;
    localparam int PIN_ALIGN = 1;
    localparam int PIN_POWERDOWN_PIN = 2;
    localparam int PIN_SENSE = 3;
    localparam int PIN_COUNT = 4;

    // clamp a requested ratio into the legal range
    function automatic logic [3:0] acdpc_clamp_ratio(input logic [3:0] r);
        if (r < DIV_MIN) begin
            return DIV_MIN;
        end else if (r > DIV_MAX) begin
            return DIV_MAX;
        end
        return r;
    endfunction
endpackage

// ===== hdl/acdpc_pin_if.sv
// interface: raw pins in, synchronised levels and edges out
`timescale 1ns/1ps
interface acdpc_pin_if #(parameter int W = 4);
    logic [W-1:0] raw;
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    modport sync (input raw, output level, output rise, output fall);
    modport user (output raw, input level, input rise, input fall);
endinterface

// ===== hdl/acdpc_pin_sync.sv
// module: three-stage pin synchroniser with level filter and edges
`timescale 1ns/1ps
module acdpc_pin_sync #(
    parameter int W = 4
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    acdpc_pin_if.sync pins
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] stage2_ff;
    logic [W-1:0] stage3_ff;
    logic [W-1:0] level_ff;
    logic [W-1:0] rise_ff;
    logic [W-1:0] fall_ff;

    // a change counts only when stages two and three agree
    wire [W-1:0] agree = ~(stage2_ff ^ stage3_ff);
    wire [W-1:0] nxt_level = (agree & stage3_ff) | (~agree & level_ff);

    // meta_ff feeds stage2_ff only, never any logic
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= '0;
            stage2_ff <= '0;
            stage3_ff <= '0;
            level_ff <= '0;
            rise_ff <= '0;
            fall_ff <= '0;
        end else begin
            meta_ff <= pins.raw;
            stage2_ff <= meta_ff;
            stage3_ff <= stage2_ff;
            level_ff <= nxt_level;
            rise_ff <= nxt_level & ~level_ff;
            fall_ff <= ~nxt_level & level_ff;
        end
    end

    assign pins.level = level_ff;
    assign pins.rise = rise_ff;
    assign pins.fall = fall_ff;

    // one rising edge pulse per filtered low-to-high change
    a_edge_single: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rise_ff[1] |=> !rise_ff[1])
        else $error("alignment edge pulse lasted more than one cycle");
endmodule

// ===== test/acdpc_partner.sv
// model of the external sample clock source and alignment driver
`timescale 1ns/1ps
module acdpc_partner (
    input wire logic clk_sys,
    input wire logic run,
    input wire logic [7:0] half_cyc,
    output logic sample_clk_in,
    output logic align_in
);
    logic [7:0] cnt = 8'h00;

    initial begin
        sample_clk_in = 1'b0;
        align_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // source runs only while enabled; stands low when stopped
    always @(negedge clk_sys) begin
        if (!run) begin
            sample_clk_in <= 1'b0;
            cnt <= 8'h00;
        end else if (cnt + 8'h01 >= half_cyc) begin
            sample_clk_in <= ~sample_clk_in;
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////
    // one clean pulse, both levels held past the pin filter
    task automatic pulse_align();
        @(negedge clk_sys);
        align_in = 1'b1;
        repeat (8) @(negedge clk_sys);
        align_in = 1'b0;
        repeat (8) @(negedge clk_sys);
    endtask
endmodule

// ===== test/adc_clock_divider_power_control_bench.sv
// testbench for the clock divider and power control block
`timescale 1ns/1ps
module adc_clock_divider_power_control_bench import acdpc_pkg::*; ;
    logic clk_sys, arst_n, run, pd_pin, sense, dcs_en, spi_pd, spi_sb, lvds_red;
    logic sample_clk_in, align_in, wr_en, rd_en;
    logic [7:0] half, wdata, reg_rdata;
    logic [3:0] div_ratio;
    logic [12:0] addr;
    logic sample_strobe, int_clk, dcs_locked, ref_en, int_ref_en, ext_ref_sel;
    logic refbuf_en, bias_en, core_clk_en, drv_oe, core_ready;
    logic [1:0] drv_code;
    int failures = 0;
    int cmp_count = 0;

    acdpc_partner partner (.clk_sys(clk_sys), .run(run), .half_cyc(half),
        .sample_clk_in(sample_clk_in), .align_in(align_in));

    // short wake cap keeps power scenarios brief
    acdpc_top #(.WAKE_MAX_CYC(16'h0010)) uut (
        .clk_sys(clk_sys), .arst_n(arst_n), .sample_clk_in(sample_clk_in),
        .align_in(align_in), .powerdown_pin(pd_pin), .ref_sense_high(sense),
        .div_ratio(div_ratio), .duty_cycle_stabilizer_en(dcs_en),
        .spi_powerdown(spi_pd), .spi_standby(spi_sb), .lvds_reduced(lvds_red),
        .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(reg_rdata), .sample_strobe(sample_strobe), .int_clk(int_clk),
        .dcs_locked(dcs_locked), .ref_en(ref_en), .int_ref_en(int_ref_en),
        .ext_ref_sel(ext_ref_sel), .refbuf_en(refbuf_en), .bias_en(bias_en),
        .core_clk_en(core_clk_en), .drv_oe(drv_oe), .core_ready(core_ready),
        .drive_current_code(drv_code));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////
    // verdict and shared helpers
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk_sys);
        wr_en = 1'b0;
    endtask

    // read data stands exactly one cycle after the strobe, then goes idle
    task automatic rd(input logic [12:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk_sys);
        rd_en = 1'b0;
        d = reg_rdata;
        @(negedge clk_sys);
        check(reg_rdata, RDATA_IDLE);
    endtask

    task automatic wait_strobe(output int gap);
        gap = 0;
        do begin
            @(negedge clk_sys);
            gap++;
        end while (sample_strobe !== 1'b1 && gap < 300);
    endtask

    task automatic count_strobes(input int n, output logic [15:0] c);
        c = 16'h0000;
        repeat (n) begin
            @(negedge clk_sys);
            if (sample_strobe === 1'b1) c++;
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic reset_case();
        logic [7:0] d;
        check({ref_en, int_ref_en, ext_ref_sel, drv_oe, core_ready}, 16'h001B);
        check(drv_code, DRV_STD_3P5MA);
        rd(ALIGN_CTRL_ADDR, d);
        check(d, ALIGN_CTRL_RST);
        wr(13'h0108, 8'h03);
        rd(ALIGN_CTRL_ADDR, d);
        check(d, ALIGN_CTRL_RST);
        rd(13'h0108, d);
        check(d, RDATA_IDLE);
    endtask

    task automatic pin_case();
        for (int i = 0; i < 2; i++) begin
            @(negedge clk_sys);
            sense = i[0];
            lvds_red = i[0];
            repeat (8) @(negedge clk_sys);
            check({int_ref_en, ext_ref_sel}, {~i[0], i[0]});
            check(drv_code, i[0] ? DRV_REDUCED_2MA : DRV_STD_3P5MA);
        end
        sense = 1'b0;
        lvds_red = 1'b0;
    endtask

    // out-of-range ratios clamp to the nearest legal end
    task automatic ratio_case();
        logic [15:0] c;
        logic [3:0] r;
        int e;
        int g;
        for (int i = 0; i < 10; i++) begin
            r = (i == 9) ? 4'hF : 4'(i);
            e = (r == 0) ? 1 : ((r > 8) ? 8 : r);
            div_ratio = r;
            wait_strobe(g);
            wait_strobe(g);
            count_strobes(32 * e, c);
            check(c, 16'h0004);
        end
    endtask

    // a taken pulse makes the next strobe come early
    task automatic align_case(input logic [7:0] ctrl, input logic [1:0] fast);
        logic [7:0] d;
        int gap;
        div_ratio = DIV_MAX;
        wr(ALIGN_CTRL_ADDR, ctrl);
        rd(ALIGN_CTRL_ADDR, d);
        check(d & 8'h03, ctrl);
        if (ctrl[1]) check(d, 8'h07);
        for (int k = 0; k < 2; k++) begin
            wait_strobe(gap);
            repeat (20) @(negedge clk_sys);
            fork
                partner.pulse_align();
                wait_strobe(gap);
            join
            check(gap < 34, fast[k]);
        end
        if (ctrl[1]) begin
            rd(ALIGN_CTRL_ADDR, d);
            check(d, 8'h03);
        end
    endtask

    task automatic power_case(input int m, input int dwell, output int wake);
        logic [15:0] c;
        @(negedge clk_sys);
        spi_pd = (m == 0);
        pd_pin = (m == 1);
        spi_sb = (m == 2);
        repeat (8) @(negedge clk_sys);
        check({drv_oe, core_clk_en, bias_en, refbuf_en, core_ready}, 16'h0000);
        check(ref_en, (m == 2));
        count_strobes(dwell, c);
        check(c | int_clk, 16'h0000);
        spi_pd = 1'b0;
        pd_pin = 1'b0;
        spi_sb = 1'b0;
        wake = 0;
        while (core_ready !== 1'b1 && wake < 100) begin
            @(negedge clk_sys);
            wake++;
        end
        check({core_ready, drv_oe, ref_en}, 16'h0007);
    endtask

    task automatic dcs_case();
        int n;
        div_ratio = 4'h2;
        dcs_en = 1'b1;
        for (int p = 0; p < 3; p++) begin
            half = (p == 1) ? 8'd20 : 8'd4;
            n = 0;
            // hold off until the loop settles after each rate change
            while (dcs_locked !== (p != 1) && n < 4000) begin
                @(negedge clk_sys);
                n++;
            end
            check(dcs_locked, p != 1);
        end
        n = 0;
        while (int_clk !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        n = 0;
        while (int_clk === 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        check(n >= 7 && n <= 9, 16'h0001);
        dcs_en = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        int w1, w2, w3, w4;
        arst_n = 1'b0;
        run = 1'b0;
        half = 8'd4;
        {pd_pin, sense, dcs_en, spi_pd, spi_sb, lvds_red, wr_en, rd_en} = 8'h00;
        wdata = 8'h00;
        addr = 13'h0000;
        div_ratio = DIV_MIN;
        repeat (8) @(negedge clk_sys);
        arst_n = 1'b1;
        run = 1'b1;
        reset_case();
        pin_case();
        ratio_case();
        align_case(8'h00, 2'b00);
        align_case(8'h01, 2'b11);
        align_case(8'h03, 2'b01);
        power_case(0, 1, w1);
        power_case(0, 200, w2);
        power_case(2, 200, w3);
        power_case(1, 30, w4);
        check(w2 > w1, 16'h0001);
        check(w3 < w2, 16'h0001);
        dcs_case();
        complete_run();
    end

    initial begin
        #(5 * 60000);
        failures++;
        complete_run();
    end
endmodule
